// ===== verilog/ifts_frame_formatter.v
// Frame formatter: pixel packing, test image and tagged trailer sections
`timescale 1ns/100ps
`default_nettype none
`include "ifts_consts.vh"
module ifts_frame_formatter (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        expo_start,
    input  wire        pix_valid,
    output wire        pix_ready,
    input  wire [11:0] pix_data,
    input  wire        pix_eol,
    input  wire        pix_last,
    output reg         out_valid,
    input  wire        out_ready,
    output reg  [7:0]  out_data,
    output reg         out_last
);
    localparam ST_IMG = 1'b0;
    localparam ST_TRL = 1'b1;
    localparam [1:0] SEC_EXT   = 2'd0;
    localparam [1:0] SEC_STAMP = 2'd1;
    localparam [1:0] SEC_CRC   = 2'd2;
    localparam [1:0] SEC_NONE  = 2'd3;

    // Register file
    reg [2:0]  fmt_q;
    reg        wide_q;
    reg        ext_en_q;
    reg        test_en_q;
    reg        stamp_en_q;
    reg        crc_en_q;
    reg [31:0] stamp_q;
    reg [31:0] last_crc_q;
    reg [15:0] frames_q;
    reg [31:0] timer_q;
    // AXI write side
    reg [7:0]  aw_addr_q;
    reg        aw_full_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    reg        w_full_q;
    // Exposure pin synchroniser
    reg        ex_s1_q;
    reg        ex_s2_q;
    reg        ex_s3_q;
    reg        ex_lvl_q;
    // Frame engine
    reg        st_q;
    reg        in_frame_q;
    reg        phase_q;
    reg [7:0]  hi_q;
    reg        last_pend_q;
    reg        crc_cap_q;
    reg        f_wide_q;
    reg        f_test_q;
    reg        f_trl_q;
    reg        f_stamp_q;
    reg        f_crc_q;
    reg [1:0]  sec_q;
    reg [4:0]  idx_q;
    reg [15:0] x_q;
    reg [15:0] y_q;
    reg [15:0] width_q;
    reg [31:0] size_q;

    wire [31:0] crc_val;

    function [7:0] pick;
        input [127:0] v;
        input [4:0]   i;
        reg   [127:0] t;
        begin
            t = v >> {i, 3'b000};
            pick = t[7:0];
        end
    endfunction

    function [1:0] next_sec;
        input [1:0] cur;
        input       st_en;
        input       crc_en;
        begin
            if (cur == SEC_EXT && st_en) begin
                next_sec = SEC_STAMP;
            end else if (cur != SEC_CRC && crc_en) begin
                next_sec = SEC_CRC;
            end else begin
                next_sec = SEC_NONE;
            end
        end
    endfunction

    function match;
        input [7:0] a;
        input [7:0] off;
        begin
            match = (a == off);
        end
    endfunction

    // Write path: address and data taken in either order
    wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_known = match(aw_addr_q, `IFTS_OFF_FORMAT) || match(aw_addr_q, `IFTS_OFF_EXT) ||
                    match(aw_addr_q, `IFTS_OFF_TEST) || match(aw_addr_q, `IFTS_OFF_STAMP) ||
                    match(aw_addr_q, `IFTS_OFF_CRC);

    reg [31:0] rd_d;
    reg        rd_ok;
    always @* begin
        rd_d  = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `IFTS_OFF_FORMAT:    rd_d = {23'h000000, wide_q, 5'h00, fmt_q};
            `IFTS_OFF_EXT:       rd_d = {31'h00000000, ext_en_q};
            `IFTS_OFF_TEST:      rd_d = {31'h00000000, test_en_q};
            `IFTS_OFF_STAMP:     rd_d = {31'h00000000, stamp_en_q};
            `IFTS_OFF_CRC:       rd_d = {31'h00000000, crc_en_q};
            `IFTS_OFF_STATUS:    rd_d = {in_frame_q, 15'h0000, frames_q};
            `IFTS_OFF_LAST_CRC:  rd_d = last_crc_q;
            `IFTS_OFF_STAMP_VAL: rd_d = stamp_q;
            default:             rd_ok = 1'b0;
        endcase
    end

    // Live settings apply at frame start, then stay fixed for that frame
    wire c_wide  = in_frame_q ? f_wide_q  : wide_q;
    wire c_test  = in_frame_q ? f_test_q  : test_en_q;
    wire c_trl   = in_frame_q ? f_trl_q   : (ext_en_q && fmt_q == `IFTS_FMT_SCALABLE);
    wire c_stamp = in_frame_q ? f_stamp_q : stamp_en_q;
    wire c_crc   = in_frame_q ? f_crc_q   : crc_en_q;
    wire [15:0] xb = in_frame_q ? x_q : 16'h0000;
    wire [15:0] yb = in_frame_q ? y_q : 16'h0000;

    wire can_load = !out_valid || out_ready;
    wire take     = (st_q == ST_IMG) && !phase_q && pix_valid && can_load;
    wire hi_go    = (st_q == ST_IMG) && phase_q && can_load;
    assign pix_ready = (st_q == ST_IMG) && !phase_q && can_load;

    // Test image: diagonal ramp, still bounded to twelve bits
    wire [11:0] pattern = xb[11:0] + yb[11:0];
    wire [11:0] sample  = c_test ? pattern : pix_data;
    wire [7:0]  img_b   = take ? (c_wide ? sample[7:0] : sample[11:4]) : hi_q;
    wire        img_go  = take || hi_go;
    wire        img_fin = take ? (!c_wide && pix_last) : last_pend_q;

    wire [127:0] tag = (sec_q == SEC_EXT) ? `IFTS_TAG_EXT :
                       (sec_q == SEC_STAMP) ? `IFTS_TAG_STAMP : `IFTS_TAG_CRC;
    wire [63:0]  pay = (sec_q == SEC_EXT) ? {size_q, width_q, y_q} :
                       (sec_q == SEC_STAMP) ? {32'h00000000, stamp_q} :
                       {32'h00000000, crc_val};
    wire [4:0]   pay_i  = idx_q - 5'h10;
    wire [7:0]   trl_b  = (idx_q <= `IFTS_TAG_LAST) ? pick(tag, idx_q) :
                          pick({64'h0, pay}, pay_i);
    wire [4:0]   sec_end = (sec_q == SEC_EXT) ? `IFTS_EXT_LAST : `IFTS_WORD_LAST;
    wire [1:0]   nxt     = next_sec(sec_q, f_stamp_q, f_crc_q);

    ifts_crc32 u_crc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .init    (take && !in_frame_q),
        .en      (img_go),
        .data    (img_b),
        .crc     (crc_val)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            fmt_q <= `IFTS_FMT_RST;
            wide_q <= 1'b0;
            ext_en_q <= 1'b0;
            test_en_q <= 1'b0;
            stamp_en_q <= 1'b0;
            crc_en_q <= 1'b0;
            stamp_q <= 32'h00000000;
            last_crc_q <= 32'h00000000;
            crc_cap_q <= 1'b0;
            frames_q <= 16'h0000;
            timer_q <= 32'h00000000;
            aw_addr_q <= 8'h00;
            aw_full_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IFTS_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `IFTS_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            ex_s1_q <= 1'b0;
            ex_s2_q <= 1'b0;
            ex_s3_q <= 1'b0;
            ex_lvl_q <= 1'b0;
            st_q <= ST_IMG;
            in_frame_q <= 1'b0;
            phase_q <= 1'b0;
            hi_q <= 8'h00;
            last_pend_q <= 1'b0;
            f_wide_q <= 1'b0;
            f_test_q <= 1'b0;
            f_trl_q <= 1'b0;
            f_stamp_q <= 1'b0;
            f_crc_q <= 1'b0;
            sec_q <= SEC_EXT;
            idx_q <= 5'h00;
            x_q <= 16'h0000;
            y_q <= 16'h0000;
            width_q <= 16'h0000;
            size_q <= 32'h00000000;
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_last <= 1'b0;
        end else begin
            timer_q <= timer_q + 32'h00000001;
            ex_s1_q <= expo_start;
            ex_s2_q <= ex_s1_q;
            ex_s3_q <= ex_s2_q;
            crc_cap_q <= 1'b0;
            // Level moves only once both late stages agree, so glitches are dropped
            if (ex_s2_q == ex_s3_q) begin
                ex_lvl_q <= ex_s3_q;
            end
            if (stamp_en_q && ex_s2_q && ex_s3_q && !ex_lvl_q) begin
                stamp_q <= timer_q;
            end
            // Final image byte enters the checksum on the same edge, so capture a cycle later
            if (crc_cap_q) begin
                last_crc_q <= crc_val;
            end

            if (s_axi_awvalid && !aw_full_q) begin
                aw_addr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `IFTS_RESP_OKAY : `IFTS_RESP_SLVERR;
                if (w_strb_q[0]) begin
                    case (aw_addr_q)
                        `IFTS_OFF_FORMAT: fmt_q <= w_data_q[`IFTS_FMT_MSB:`IFTS_FMT_LSB];
                        `IFTS_OFF_EXT:    ext_en_q <= w_data_q[`IFTS_EN_BIT];
                        `IFTS_OFF_TEST:   test_en_q <= w_data_q[`IFTS_EN_BIT];
                        `IFTS_OFF_STAMP:  stamp_en_q <= w_data_q[`IFTS_EN_BIT];
                        `IFTS_OFF_CRC:    crc_en_q <= w_data_q[`IFTS_EN_BIT];
                        default:          fmt_q <= fmt_q;
                    endcase
                end
                if (w_strb_q[1] && aw_addr_q == `IFTS_OFF_FORMAT) begin
                    wide_q <= w_data_q[`IFTS_WIDE_BIT];
                end
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok ? `IFTS_RESP_OKAY : `IFTS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end

            if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (take) begin
                in_frame_q <= 1'b1;
                f_wide_q <= c_wide;
                f_test_q <= c_test;
                f_trl_q <= c_trl;
                f_stamp_q <= c_stamp;
                f_crc_q <= c_crc;
                hi_q <= {4'h0, sample[11:8]};
                phase_q <= c_wide;
                last_pend_q <= pix_last;
                x_q <= pix_eol ? 16'h0000 : xb + 16'h0001;
                y_q <= pix_eol ? yb + 16'h0001 : yb;
                if (pix_eol && yb == 16'h0000) begin
                    width_q <= xb + 16'h0001;
                end
            end
            if (hi_go) begin
                phase_q <= 1'b0;
            end
            if (img_go) begin
                out_valid <= 1'b1;
                out_data <= img_b;
                size_q <= (take && !in_frame_q) ? 32'h00000001 : size_q + 32'h00000001;
                out_last <= img_fin && !c_trl;
                if (img_fin) begin
                    if (c_trl) begin
                        st_q <= ST_TRL;
                        sec_q <= SEC_EXT;
                        idx_q <= 5'h00;
                    end else begin
                        in_frame_q <= 1'b0;
                        frames_q <= frames_q + 16'h0001;
                        crc_cap_q <= 1'b1;
                    end
                end
            end
            if (st_q == ST_TRL && can_load) begin
                out_valid <= 1'b1;
                out_data <= trl_b;
                out_last <= 1'b0;
                idx_q <= idx_q + 5'h01;
                if (idx_q == sec_end) begin
                    idx_q <= 5'h00;
                    sec_q <= nxt;
                    if (nxt == SEC_NONE) begin
                        out_last <= 1'b1;
                        st_q <= ST_IMG;
                        in_frame_q <= 1'b0;
                        frames_q <= frames_q + 16'h0001;
                        last_crc_q <= crc_val;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/ifts_consts.vh
// Constants for the image frame trailer formatter
`ifndef IFTS_CONSTS_VH
`define IFTS_CONSTS_VH

`define IFTS_OFF_FORMAT    8'h00
`define IFTS_OFF_EXT       8'h04
`define IFTS_OFF_TEST      8'h08
`define IFTS_OFF_STAMP     8'h0c
`define IFTS_OFF_CRC       8'h10
`define IFTS_OFF_STATUS    8'h14
`define IFTS_OFF_LAST_CRC  8'h18
`define IFTS_OFF_STAMP_VAL 8'h1c

`define IFTS_FMT_LSB       0
`define IFTS_FMT_MSB       2
`define IFTS_WIDE_BIT      8
`define IFTS_EN_BIT        0
`define IFTS_BUSY_BIT      31
`define IFTS_FMT_RST       3'h0
`define IFTS_FMT_SCALABLE  3'h7

`define IFTS_RESP_OKAY     2'h0
`define IFTS_RESP_SLVERR   2'h2

`define IFTS_SAMPLE_MAX    12'hfff
`define IFTS_TAG_LAST      5'h0f
`define IFTS_EXT_LAST      5'h17
`define IFTS_WORD_LAST     5'h13

// Tag values are arbitrary
`define IFTS_TAG_EXT       128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
`define IFTS_TAG_STAMP     128'h1111222233334444555566667777aaaa
`define IFTS_TAG_CRC       128'h0123456789abcdeffedcba9876543210

`define IFTS_CRC_INIT      32'hffffffff
`define IFTS_CRC_POLY      32'hedb88320

`endif

// ===== verilog/ifts_crc32.v
// Byte-wise CRC-32 accumulator for transmitted image bytes
`timescale 1ns/100ps
`default_nettype none
`include "ifts_consts.vh"
module ifts_crc32 (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        init,
    input  wire        en,
    input  wire [7:0]  data,
    output wire [31:0] crc
);
    reg [31:0] crc_q;

    function [31:0] step;
        input [31:0] c;
        input [7:0]  d;
        reg   [31:0] t;
        integer      i;
        begin
            t = c ^ {24'h000000, d};
            for (i = 0; i < 8; i = i + 1) begin
                t = t[0] ? ((t >> 1) ^ `IFTS_CRC_POLY) : (t >> 1);
            end
            step = t;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            crc_q <= `IFTS_CRC_INIT;
        end else if (en) begin
            crc_q <= step(init ? `IFTS_CRC_INIT : crc_q, data);
        end else if (init) begin
            crc_q <= `IFTS_CRC_INIT;
        end
    end

    assign crc = ~crc_q;
endmodule
`default_nettype wire

// ===== dv/ifts_frame_sva.sv
// Port checker for the frame formatter
`timescale 1ns/100ps
`default_nettype none
module ifts_frame_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        pix_valid,
    input wire logic        pix_ready,
    input wire logic [11:0] pix_data,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [7:0]  out_data,
    input wire logic        out_last
);
    logic [11:0] hold_q;
    logic [1:0]  ph_q;
    logic        wide_q;
    logic        test_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence pix_taken_s;
        pix_valid && pix_ready && wide_q && !test_q;
    endsequence
    sequence low_taken_s;
        out_valid && out_ready && ph_q == 2'h1;
    endsequence
    // Mode mirror assumes address and data are offered together
    always @(posedge aclk) begin
        if (!aresetn) begin
            ph_q <= 2'h0;
            wide_q <= 1'b0;
            test_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
                if (s_axi_awaddr == 8'h00) wide_q <= s_axi_wdata[8];
                if (s_axi_awaddr == 8'h08) test_q <= s_axi_wdata[0];
            end
            if (pix_valid && pix_ready && wide_q && !test_q) begin
                ph_q <= 2'h1;
                hold_q <= pix_data;
            end else if (out_valid && out_ready && ph_q != 2'h0) begin
                ph_q <= (ph_q == 2'h1) ? 2'h2 : 2'h0;
            end
        end
    end
    low_byte_a: assert property (pix_taken_s |=> out_valid && out_data == hold_q[7:0])
        else $error("low byte wrong");
    high_byte_a: assert property (low_taken_s |=> out_valid && out_data == {4'h0, hold_q[11:8]})
        else $error("high byte wrong");
    pix_refuse_a: assert property (ph_q[0] || (ph_q[1] && !out_ready) |-> !pix_ready)
        else $error("pixel taken mid word");
    pix_gate_a: assert property (pix_ready |-> !out_valid || out_ready)
        else $error("pixel taken while output stalled");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("output byte not held");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind ifts_frame_formatter ifts_frame_sva u_sva (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .pix_valid, .pix_ready, .pix_data, .out_valid, .out_ready,
    .out_data, .out_last
);
`default_nettype wire

// ===== dv/ifts_host_sink.sv
// Host-side byte sink with optional back-pressure
`timescale 1ns/100ps
`default_nettype none
module ifts_host_sink (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       stall_en,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    output var  logic       out_ready
);
    integer     seed = 10;
    logic [8:0] rx_q[$];
    always @(posedge aclk) begin
        if (!aresetn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= stall_en ? (($random(seed) & 1) != 0) : 1'b1;
            if (out_valid && out_ready) rx_q.push_back({out_last, out_data});
        end
    end
endmodule
`default_nettype wire

// ===== dv/image_frame_trailer_formatter_test.sv
// Self-checking bench for the frame formatter
`timescale 1ns/100ps
`default_nettype none
`include "ifts_consts.vh"
module image_frame_trailer_formatter_test;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, out_data;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, crc;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, pix_valid = 0, pix_eol = 0, pix_last = 0, expo_start = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        pix_ready, out_valid, out_ready, out_last, stall = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [11:0] pix_data = 12'h0;
    logic [31:0] rd;
    integer      error_cnt = 0, samples_checked = 0, seed = 10, cycles = 0, frames = 0;
    int          exp_q[$];
    ifts_frame_formatter dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .expo_start, .pix_valid, .pix_ready, .pix_data, .pix_eol, .pix_last,
        .out_valid, .out_ready, .out_data, .out_last
    );
    ifts_host_sink host (.aclk, .aresetn, .stall_en(stall), .out_valid, .out_data, .out_last,
        .out_ready);
    always #50 aclk = ~aclk;
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", r, s_axi_bresp);
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    function automatic void put(input logic [127:0] v, input int nb, input bit img);
        for (int i = 0; i < nb; i++) begin
            exp_q.push_back(v[8*i +: 8]);
            if (img) begin
                crc = crc ^ v[8*i +: 8];
                repeat (8) crc = crc[0] ? (crc >> 1) ^ `IFTS_CRC_POLY : crc >> 1;
            end
        end
    endfunction
    task automatic run_frame(input logic [2:0] fmt, input logic wd, ext, tst, stp, cen);
        logic [11:0] v;
        logic [8:0]  got;
        int          n, ts;
        axi_write(8'h00, {23'h0, wd, 5'h0, fmt}, `IFTS_RESP_OKAY);
        axi_write(8'h04, ext, `IFTS_RESP_OKAY);
        axi_write(8'h08, tst, `IFTS_RESP_OKAY);
        axi_write(8'h0c, stp, `IFTS_RESP_OKAY);
        axi_write(8'h10, cen, `IFTS_RESP_OKAY);
        exp_q.delete();
        crc = `IFTS_CRC_INIT;
        expo_start <= 1'b1;
        // Free counter value at the edge where the filtered pin is seen high
        ts = cycles - 1;
        repeat (2) @(posedge aclk);
        expo_start <= 1'b0;
        for (int y = 0; y < 2; y++) for (int x = 0; x < 3; x++) begin
            pix_data <= (x == 1 && y == 1) ? 12'hfff : 12'($random(seed));
            v = tst ? 12'(x + y) : ((x == 1 && y == 1) ? 12'hfff : pix_data);
            pix_valid <= 1'b1;
            pix_eol <= (x == 2);
            pix_last <= (x == 2 && y == 1);
            @(posedge aclk);
            v = tst ? 12'(x + y) : pix_data;
            if (wd) put({4'h0, v}, 2, 1);
            else put(v[11:4], 1, 1);
            while (!pix_ready) @(posedge aclk);
        end
        pix_valid <= 1'b0;
        n = exp_q.size();
        if (fmt == `IFTS_FMT_SCALABLE && ext) begin
            put(`IFTS_TAG_EXT, 16, 0);
            put({32'(n), 16'h3, 16'h2}, 8, 0);
            if (stp) put(`IFTS_TAG_STAMP, 16, 0);
            if (stp) put(ts, 4, 0);
            if (cen) put(`IFTS_TAG_CRC, 16, 0);
            if (cen) put(~crc, 4, 0);
        end
        while (host.rx_q.size() < exp_q.size()) @(posedge aclk);
        repeat (30) @(posedge aclk);
        check("frame bytes", exp_q.size(), host.rx_q.size());
        foreach (exp_q[i]) begin
            got = host.rx_q.pop_front();
            if (exp_q[i] >= 0) check("out_data", exp_q[i], got[7:0]);
            check("out_last", i == exp_q.size() - 1, got[8]);
        end
        host.rx_q.delete();
        frames++;
        axi_read(8'h14);
        check("frames done", frames, rd[15:0]);
        axi_read(8'h18);
        check("last crc", ~crc, rd);
        if (stp) begin
            axi_read(8'h1c);
            check("stamp reg", ts, rd);
        end
        $display("frame %0d done", frames);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h00);
        check("format reset", 32'h0, rd);
        axi_read(8'hfc);
        check("unmapped rresp", `IFTS_RESP_SLVERR, rr);
        check("unmapped rdata", 32'h0, rd);
        axi_write(8'h40, 32'h1, `IFTS_RESP_SLVERR);
        $display("register test done");
        run_frame(3'h0, 1, 1, 0, 1, 1);
        run_frame(3'h7, 1, 0, 0, 1, 1);
        stall <= 1'b1;
        run_frame(3'h7, 1, 1, 0, 1, 1);
        run_frame(3'h7, 1, 1, 1, 0, 0);
        run_frame(3'h7, 0, 1, 0, 0, 1);
        complete_run();
    end
endmodule
`default_nettype wire
